// ==== src/cmd_decoder_pkg.sv ====
package cmd_decoder_pkg;
  // ---------------------------------------------------------------
  // packet framing
  // ---------------------------------------------------------------
  localparam int          MAX_LEN        = 18;
  localparam int          LINE_CHARS     = 16;
  localparam int          USER_BYTES     = 16;
  localparam int          GLYPHS         = 8;
  localparam int          GLYPH_ROWS     = 8;
  localparam int          ROW_BITS       = 6;
  localparam logic [1:0]  KIND_COMMAND   = 2'h0;
  localparam logic [1:0]  KIND_RESPONSE  = 2'h1;
  localparam logic [1:0]  KIND_ERROR     = 2'h3;
  localparam logic [7:0]  BLANK_CHAR     = 8'h20;
  localparam logic [7:0]  PING_MAX_LEN   = 8'h10;
  localparam logic [7:0]  LEN_LINE       = 8'h10;
  localparam logic [7:0]  LEN_GLYPH      = 8'h09;
  localparam logic [7:0]  LEN_CONTROL    = 8'h03;
  localparam logic [7:0]  LEN_VERSION    = 8'h10;
  localparam logic [7:0]  GLYPH_IDX_MAX  = 8'h07;
  localparam logic [7:0]  ROW_VALUE_MAX  = 8'h3F;

  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [5:0] CMD_PING        = 6'h00;
  localparam logic [5:0] CMD_VERSION     = 6'h01;
  localparam logic [5:0] CMD_USER_WRITE  = 6'h02;
  localparam logic [5:0] CMD_USER_READ   = 6'h03;
  localparam logic [5:0] CMD_SAVE_BOOT   = 6'h04;
  localparam logic [5:0] CMD_CONTROL     = 6'h05;
  localparam logic [5:0] CMD_CLEAR       = 6'h06;
  localparam logic [5:0] CMD_LINE_TOP    = 6'h07;
  localparam logic [5:0] CMD_LINE_BOTTOM = 6'h08;
  localparam logic [5:0] CMD_GLYPH       = 6'h09;

  // control key triples
  localparam logic [23:0] KEY_REBOOT     = {8'h08, 8'h12, 8'h63};
  localparam logic [23:0] KEY_HOST_RESET = {8'h0C, 8'h1C, 8'h61};
  localparam logic [23:0] KEY_HOST_OFF   = {8'h03, 8'h0B, 8'h5F};

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ          = 10_000_000;
  localparam int ACK_LIMIT_MS    = 250;
  localparam int ACK_LIMIT_CYC   = (CLK_HZ / 1000) * ACK_LIMIT_MS;
  localparam int HOST_PULSE_US   = 100;
  localparam int HOST_PULSE_CYC  = (CLK_HZ / 1_000_000) * HOST_PULSE_US;

  typedef logic [7:0] byte_t;
endpackage

// ==== src/reply_if.sv ====
`timescale 1ns/1ns
`default_nettype none
// reply stream from the decoder core to the reply sender
interface reply_if;
  import cmd_decoder_pkg::*;
  logic       start;
  logic [7:0] rtype;
  logic [7:0] rlen;
  logic       busy;
  logic [4:0] idx;
  logic [7:0] data;
  modport core   (output start, output rtype, output rlen, input busy, input idx, output data);
  modport sender (input start, input rtype, input rlen, output busy, output idx, input data);
endinterface
`default_nettype wire

// ==== src/reply_sender.sv ====
`timescale 1ns/1ns
`default_nettype none
module reply_sender
  import cmd_decoder_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic srst,
  reply_if.sender   rif,
  output logic      tx_valid,
  input  wire logic tx_ready,
  output logic      tx_first,
  output logic      tx_last,
  output logic [7:0] tx_data
);
  // ---------------------------------------------------------------
  // byte streamer: type, length, payload; crc appended downstream
  // ---------------------------------------------------------------
  logic [5:0] pos;
  logic [7:0] len;
  logic [7:0] next_byte;

  assign rif.idx  = 5'(pos - 6'h02);
  assign rif.busy = tx_valid;

  always_comb
  begin
    next_byte = rif.data;
    if (pos == 6'h00)
      next_byte = rif.rtype;
    else if (pos == 6'h01)
      next_byte = len;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      tx_valid <= 1'b0;
      tx_first <= 1'b0;
      tx_last  <= 1'b0;
      tx_data  <= 8'h00;
      pos      <= 6'h00;
      len      <= 8'h00;
    end
    else if (!tx_valid && rif.start)
    begin
      len      <= rif.rlen;
      tx_valid <= 1'b1;
      tx_first <= 1'b1;
      tx_last  <= 1'b0;
      tx_data  <= rif.rtype;
      pos      <= 6'h01;
    end
    else if (tx_valid && tx_ready)
    begin
      if (tx_last)
        tx_valid <= 1'b0;
      else
      begin
        tx_first <= 1'b0;
        tx_data  <= next_byte;
        tx_last  <= (6'(len) + 6'h01 == pos);
        pos      <= pos + 6'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ==== src/lcd_module_command_decoder.sv ====
// Behaviour
// - type byte: two kind bits, six code bits
// - crc checked before us, appended after us
// - every command acknowledged within 250 ms
// - reply repeats the six-bit command code
// - ping echoes length and payload, type 0x40
// - version query returns sixteen ascii bytes
// - sixteen bytes stored in user area
// - user area read back, type 0x43
// - power-up loads boot state from storage
// - save current state as boot state
// - temperature reporting and watchdog not saved
// - key 8,18,99 restarts module
// - key 12,28,97 pulses host reset pin
// - key 3,11,95 switches host power off
// - control actions acknowledged with type 0x45
// - clear fills memory with blanks, cursor home
// - sixteen bytes written to top line
// - sixteen bytes written to bottom line
// - nine bytes redefine one special glyph
// - six-bit rows, first byte top row
`timescale 1ns/1ns
`default_nettype none
module lcd_module_command_decoder
  import cmd_decoder_pkg::*;
#(
  parameter int          ACK_CYCLES   = ACK_LIMIT_CYC,
  parameter logic [127:0] VERSION_TEXT = "MOD000:h0.0,s0v0"  // arbitrary identity string
)
(
  input  wire logic                  sys_clk,
  input  wire logic                  srst,
  input  wire logic                  rx_valid,
  output logic                       rx_ready,
  input  wire logic [7:0]            rx_type,
  input  wire logic [7:0]            rx_len,
  input  wire logic [MAX_LEN*8-1:0]  rx_payload,
  output logic                       tx_valid,
  input  wire logic                  tx_ready,
  output logic                       tx_first,
  output logic                       tx_last,
  output logic [7:0]                 tx_data,
  output logic [LINE_CHARS*8-1:0]    top_line,
  output logic [LINE_CHARS*8-1:0]    bottom_line,
  output logic [GLYPHS*GLYPH_ROWS*ROW_BITS-1:0] glyph_pattern_memory,
  output logic [4:0]                 cursor_col,
  output logic                       cursor_row,
  output logic                       nv_user_write,
  output logic [USER_BYTES*8-1:0]    nv_user_wdata,
  input  wire logic [USER_BYTES*8-1:0] nv_user_rdata,
  output logic                       nv_save_boot,
  input  wire logic                  boot_valid,
  input  wire logic [LINE_CHARS*8-1:0] boot_top,
  input  wire logic [LINE_CHARS*8-1:0] boot_bottom,
  output logic                       module_restart,
  output logic                       host_reset,
  output logic                       host_power_off,
  output logic                       ack_overdue
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {IDLE, LOAD, REPLY, WAIT} state_t;
  state_t state;

  logic [7:0]             cmd_type;
  logic [7:0]             cmd_len;
  logic [MAX_LEN*8-1:0]   cmd_data;
  logic [7:0]             reply_type;
  logic [7:0]             reply_len;
  logic [USER_BYTES*8-1:0] reply_buf;
  logic                   cmd_ok;
  logic [7:0]             ok_len;
  logic                   booted;
  logic [$clog2(HOST_PULSE_CYC+1)-1:0] pulse_cnt;
  logic [$clog2(ACK_CYCLES+1)-1:0]     ack_cnt;
  logic [23:0]            key;
  logic                   rows_ok;
  logic [5:0]             code;

  reply_if rif ();

  assign code = cmd_type[5:0];
  // first payload byte sits in the top of the key so it lines up with the key constants
  assign key  = {cmd_data[7:0], cmd_data[15:8], cmd_data[23:16]};
  assign rx_ready = (state == IDLE);

  function automatic logic [7:0] pbyte(input logic [MAX_LEN*8-1:0] p, input int i);
    pbyte = p[i*8 +: 8];
  endfunction

  // glyph rows must fit in six bits
  always_comb
  begin
    rows_ok = 1'b1;
    for (int r = 1; r <= GLYPH_ROWS; r++)
      if (pbyte(cmd_data, r) > ROW_VALUE_MAX)
        rows_ok = 1'b0;
  end

  // ---------------------------------------------------------------
  // validation
  // ---------------------------------------------------------------
  always_comb
  begin
    cmd_ok = 1'b0;
    ok_len = 8'h00;
    if (cmd_type[7:6] == KIND_COMMAND)
    begin
      case (code)
        CMD_PING:
        begin
          cmd_ok = (cmd_len <= PING_MAX_LEN);
          ok_len = cmd_len;
        end
        CMD_VERSION:
        begin
          cmd_ok = (cmd_len == 8'h00);
          ok_len = LEN_VERSION;
        end
        CMD_USER_WRITE:  cmd_ok = (cmd_len == LEN_LINE);
        CMD_USER_READ:
        begin
          cmd_ok = (cmd_len == 8'h00);
          ok_len = LEN_LINE;
        end
        CMD_SAVE_BOOT:   cmd_ok = (cmd_len == 8'h00);
        CMD_CONTROL:     cmd_ok = (cmd_len == LEN_CONTROL) &&
                                  (key == KEY_REBOOT || key == KEY_HOST_RESET ||
                                   key == KEY_HOST_OFF);
        CMD_CLEAR:       cmd_ok = (cmd_len == 8'h00);
        CMD_LINE_TOP:    cmd_ok = (cmd_len == LEN_LINE);
        CMD_LINE_BOTTOM: cmd_ok = (cmd_len == LEN_LINE);
        CMD_GLYPH:       cmd_ok = (cmd_len == LEN_GLYPH) &&
                                  (pbyte(cmd_data, 0) <= GLYPH_IDX_MAX) && rows_ok;
        default:         cmd_ok = 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state      <= IDLE;
      cmd_type   <= 8'h00;
      cmd_len    <= 8'h00;
      cmd_data   <= '0;
      reply_type <= 8'h00;
      reply_len  <= 8'h00;
      reply_buf  <= '0;
    end
    else
    begin
      case (state)
        IDLE:
          if (rx_valid)
          begin
            cmd_type <= rx_type;
            cmd_len  <= rx_len;
            cmd_data <= rx_payload;
            state    <= LOAD;
          end
        LOAD:
        begin
          // reply carries the command's own code either way
          reply_type <= {cmd_ok ? KIND_RESPONSE : KIND_ERROR, code};
          reply_len  <= cmd_ok ? ok_len : 8'h00;
          reply_buf  <= '0;
          if (cmd_ok && code == CMD_PING)
            reply_buf <= cmd_data[USER_BYTES*8-1:0];
          else if (cmd_ok && code == CMD_VERSION)
            for (int i = 0; i < USER_BYTES; i++)
              reply_buf[i*8 +: 8] <= VERSION_TEXT[(USER_BYTES-1-i)*8 +: 8];
          else if (cmd_ok && code == CMD_USER_READ)
            reply_buf <= nv_user_rdata;
          state <= REPLY;
        end
        REPLY:
          if (!rif.busy)
            state <= WAIT;
        WAIT:
          if (!rif.busy)
            state <= IDLE;
        default: state <= IDLE;
      endcase
    end
  end

  assign rif.start = (state == REPLY);
  assign rif.rtype = reply_type;
  assign rif.rlen  = reply_len;
  assign rif.data  = reply_buf[rif.idx[3:0]*8 +: 8];

  reply_sender u_sender (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .rif      (rif),
    .tx_valid (tx_valid),
    .tx_ready (tx_ready),
    .tx_first (tx_first),
    .tx_last  (tx_last),
    .tx_data  (tx_data)
  );

  // ---------------------------------------------------------------
  // display state and side effects
  // ---------------------------------------------------------------
  wire logic act = (state == LOAD) && cmd_ok;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      top_line    <= {LINE_CHARS{BLANK_CHAR}};
      bottom_line <= {LINE_CHARS{BLANK_CHAR}};
      cursor_col  <= 5'h00;
      cursor_row  <= 1'b0;
      booted      <= 1'b0;
    end
    else if (!booted && boot_valid)
    begin
      // welcome screen comes from stored boot state
      top_line    <= boot_top;
      bottom_line <= boot_bottom;
      booted      <= 1'b1;
    end
    else if (act && code == CMD_CLEAR)
    begin
      top_line    <= {LINE_CHARS{BLANK_CHAR}};
      bottom_line <= {LINE_CHARS{BLANK_CHAR}};
      cursor_col  <= 5'h00;
      cursor_row  <= 1'b0;
    end
    else if (act && code == CMD_LINE_TOP)
      top_line    <= cmd_data[LINE_CHARS*8-1:0];
    else if (act && code == CMD_LINE_BOTTOM)
      bottom_line <= cmd_data[LINE_CHARS*8-1:0];
  end

  genvar g;
  generate
    for (g = 0; g < GLYPHS; g++)
    begin : glyph_slot
      always_ff @(posedge sys_clk)
      begin
        if (srst)
          glyph_pattern_memory[g*GLYPH_ROWS*ROW_BITS +: GLYPH_ROWS*ROW_BITS] <= '0;
        else if (act && code == CMD_GLYPH && pbyte(cmd_data, 0) == 8'(g))
          for (int r = 0; r < GLYPH_ROWS; r++)
            // row 0 at the top, msb is the left pixel
            glyph_pattern_memory[(g*GLYPH_ROWS + r)*ROW_BITS +: ROW_BITS]
              <= cmd_data[(r+1)*8 +: ROW_BITS];
      end
    end
  endgenerate

  // nonvolatile strobes: the store saves only the saveable state, so
  // temperature reporting and the host watchdog never reach it
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      nv_user_write <= 1'b0;
      nv_user_wdata <= '0;
      nv_save_boot  <= 1'b0;
    end
    else
    begin
      nv_user_write <= act && code == CMD_USER_WRITE;
      if (act && code == CMD_USER_WRITE)
        nv_user_wdata <= cmd_data[USER_BYTES*8-1:0];
      nv_save_boot  <= act && code == CMD_SAVE_BOOT;
    end
  end

  // ---------------------------------------------------------------
  // control actions, fired after the ack has left
  // ---------------------------------------------------------------
  logic [1:0] pending;
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      pending        <= 2'h0;
      module_restart <= 1'b0;
      host_reset     <= 1'b0;
      host_power_off <= 1'b0;
      pulse_cnt      <= '0;
    end
    else
    begin
      module_restart <= 1'b0;
      if (act && code == CMD_CONTROL)
        pending <= (key == KEY_REBOOT) ? 2'h1 : (key == KEY_HOST_RESET) ? 2'h2 : 2'h3;
      else if (state == WAIT && !rif.busy && pending != 2'h0)
      begin
        pending <= 2'h0;
        if (pending == 2'h1)
          module_restart <= 1'b1;
        else if (pending == 2'h2)
        begin
          host_reset <= 1'b1;
          pulse_cnt  <= $bits(pulse_cnt)'(HOST_PULSE_CYC);
        end
        else
          host_power_off <= 1'b1;
      end
      if (host_reset)
      begin
        if (pulse_cnt == '0)
          host_reset <= 1'b0;
        else
          pulse_cnt <= pulse_cnt - 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // ack deadline watch
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst || state == IDLE)
    begin
      ack_cnt     <= '0;
      ack_overdue <= 1'b0;
    end
    else if (ack_cnt >= $bits(ack_cnt)'(ACK_CYCLES))
      ack_overdue <= 1'b1;
    else
      ack_cnt <= ack_cnt + 1'b1;
  end
endmodule
`default_nettype wire

// ==== testbench/lcd_cmd_checker_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
module lcd_cmd_checker
  import cmd_decoder_pkg::*;
(
  input wire logic                  sys_clk,
  input wire logic                  srst,
  input wire logic                  rx_valid,
  input wire logic                  rx_ready,
  input wire logic [7:0]            rx_type,
  input wire logic [7:0]            rx_len,
  input wire logic [MAX_LEN*8-1:0]  rx_payload,
  input wire logic                  tx_valid,
  input wire logic                  tx_ready,
  input wire logic                  tx_first,
  input wire logic                  tx_last,
  input wire logic [7:0]            tx_data,
  input wire logic [LINE_CHARS*8-1:0] top_line,
  input wire logic [LINE_CHARS*8-1:0] bottom_line,
  input wire logic [4:0]            cursor_col,
  input wire logic                  cursor_row,
  input wire logic                  nv_user_write,
  input wire logic [USER_BYTES*8-1:0] nv_user_wdata,
  input wire logic                  nv_save_boot,
  input wire logic                  host_reset
);
  logic         take;
  logic [127:0] pl_q;
  assign take = rx_valid && rx_ready;
  // payload kept so the side effect can be compared a few cycles later
  always_ff @(posedge sys_clk)
  begin
    if (take)
      pl_q <= rx_payload[127:0];
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // -------------------------------------------------------------
  // reply framing
  // -------------------------------------------------------------
  property p_ans;
    take |-> ##3 tx_valid && tx_first;
  endproperty
  a_ans: assert property (p_ans) else $error("reply not started three cycles after take");
  property p_kind;
    tx_valid && tx_first |-> tx_data[7:6] == 2'h1 || tx_data[7:6] == 2'h3;
  endproperty
  a_kind: assert property (p_kind) else $error("reply kind bits wrong");
  property p_code;
    take |-> ##3 tx_data[5:0] == $past(rx_type[5:0], 3);
  endproperty
  a_code: assert property (p_code) else $error("reply code differs from command");
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
  endproperty
  a_hold: assert property (p_hold) else $error("reply byte dropped while stalled");
  property p_busy;
    tx_valid |-> !rx_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("command taken during reply");
  // -------------------------------------------------------------
  // side effects
  // -------------------------------------------------------------
  property p_clear;
    take && rx_type == 8'h06 && rx_len == 8'h00 |-> ##[1:4] top_line == {16{8'h20}}
      && bottom_line == {16{8'h20}} && cursor_col == 5'h00 && !cursor_row;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not blank and home");
  property p_top;
    take && rx_type == 8'h07 && rx_len == 8'h10 |-> ##[1:4] top_line == pl_q;
  endproperty
  a_top: assert property (p_top) else $error("top line not written");
  property p_bot;
    take && rx_type == 8'h08 && rx_len == 8'h10 |-> ##[1:4] bottom_line == pl_q;
  endproperty
  a_bot: assert property (p_bot) else $error("bottom line not written");
  property p_user;
    take && rx_type == 8'h02 && rx_len == 8'h10 |-> ##[1:4] nv_user_write && nv_user_wdata == pl_q;
  endproperty
  a_user: assert property (p_user) else $error("user area not written");
  property p_save;
    take && rx_type == 8'h04 && rx_len == 8'h00 |-> ##[1:4] nv_save_boot;
  endproperty
  a_save: assert property (p_save) else $error("boot state not saved");
  property p_keep;
    take && rx_type == 8'h07 && rx_len != 8'h10 |=> $stable(top_line)[*4];
  endproperty
  a_keep: assert property (p_keep) else $error("malformed line write took effect");
  property p_hrst;
    $rose(host_reset) |=> host_reset[*8];
  endproperty
  a_hrst: assert property (p_hrst) else $error("host reset pulse too short");
endmodule
`default_nettype wire

// ==== testbench/host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module host_model
  import cmd_decoder_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       slow,
  input  wire logic       tx_valid,
  input  wire logic       tx_first,
  input  wire logic       tx_last,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output int              n_pkt
);
  byte_t      q[$];
  logic [1:0] cnt = 2'h0;
  initial
  begin
    tx_ready = 1'b0;
    n_pkt = 0;
  end
  // a slow host is ready one cycle in four, so replies stall mid-packet
  always @(posedge sys_clk)
  begin
    if (tx_valid && tx_ready)
    begin
      if (tx_first)
        q.delete();
      q.push_back(tx_data);
      if (tx_last)
        n_pkt <= n_pkt + 1;
    end
    cnt <= cnt + 2'h1;
    tx_ready <= #1 !slow || cnt == 2'h0;
  end
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import cmd_decoder_pkg::*;
  localparam logic [127:0] VTXT = "TST100:h1.0,s1v1"; // arbitrary identity string
  typedef struct packed {logic [7:0] t, l, b, rt, rl;} row_t;
  logic sys_clk, srst, rx_valid, rx_ready, tx_valid, tx_ready, tx_first, tx_last;
  logic slow, boot_valid, nv_user_write, nv_save_boot, module_restart, host_reset;
  logic host_power_off, ack_overdue, cursor_row;
  logic [7:0]   rx_type, rx_len, tx_data;
  logic [4:0]   cursor_col;
  logic [143:0] rx_payload;
  logic [127:0] top_line, bottom_line, nv_user_wdata, nv_user_rdata, boot_top, boot_bottom;
  logic [383:0] glyph_pattern_memory;
  int           error_cnt, checks, n_pkt, n_rst, n_hr, n_od;
  row_t rows[19] = '{
    '{8'h00, 8'h00, 8'h00, 8'h40, 8'h00}, '{8'h00, 8'h10, 8'hA0, 8'h40, 8'h10},
    '{8'h01, 8'h00, 8'h00, 8'h41, 8'h10}, '{8'h02, 8'h10, 8'h30, 8'h42, 8'h00},
    '{8'h03, 8'h00, 8'h00, 8'h43, 8'h10}, '{8'h04, 8'h00, 8'h00, 8'h44, 8'h00},
    '{8'h08, 8'h10, 8'h61, 8'h48, 8'h00}, '{8'h06, 8'h00, 8'h00, 8'h46, 8'h00},
    '{8'h07, 8'h10, 8'h41, 8'h47, 8'h00}, '{8'h09, 8'h09, 8'h02, 8'h49, 8'h00},
    '{8'h07, 8'h0F, 8'h50, 8'hC7, 8'h00}, '{8'h00, 8'h11, 8'h00, 8'hC0, 8'h00},
    '{8'h02, 8'h0F, 8'h70, 8'hC2, 8'h00}, '{8'h05, 8'h03, 8'h01, 8'hC5, 8'h00},
    '{8'h09, 8'h09, 8'h08, 8'hC9, 8'h00}, '{8'h0A, 8'h00, 8'h00, 8'hCA, 8'h00},
    '{8'h41, 8'h00, 8'h00, 8'hC1, 8'h00}, '{8'h03, 8'h01, 8'h00, 8'hC3, 8'h00},
    '{8'h03, 8'h00, 8'h00, 8'h43, 8'h10}};

  lcd_module_command_decoder #(.ACK_CYCLES(50), .VERSION_TEXT(VTXT)) dut (.sys_clk, .srst,
    .rx_valid, .rx_ready, .rx_type, .rx_len, .rx_payload, .tx_valid, .tx_ready, .tx_first,
    .tx_last, .tx_data, .top_line, .bottom_line, .glyph_pattern_memory, .cursor_col,
    .cursor_row, .nv_user_write, .nv_user_wdata, .nv_user_rdata, .nv_save_boot, .boot_valid,
    .boot_top, .boot_bottom, .module_restart, .host_reset, .host_power_off, .ack_overdue);
  host_model host (.sys_clk, .slow, .tx_valid, .tx_first, .tx_last, .tx_data, .tx_ready, .n_pkt);

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // user area storage and strobe counters
  always @(posedge sys_clk)
  begin
    if (nv_user_write)
      nv_user_rdata <= nv_user_wdata;
    n_rst <= n_rst + int'(module_restart);
    n_hr <= n_hr + int'(host_reset);
    n_od <= n_od + int'(ack_overdue);
  end

  function automatic logic [127:0] seq(input logic [7:0] b);
    for (int i = 0; i < 16; i++)
      seq[8*i+:8] = b + 8'(i);
  endfunction

  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic results;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // request held until the edge where rx_ready is high, then reply compared
  task automatic send(input logic [7:0] t, l, b, rt, rl, input logic [23:0] key = 24'h0);
    int         n0;
    logic [7:0] eb;
    n0 = n_pkt;
    rx_type = t;
    rx_len = l;
    for (int i = 0; i < MAX_LEN; i++)
      rx_payload[8*i+:8] = b + 8'(i);
    if (key != 24'h0)
      rx_payload[23:0] = {key[7:0], key[15:8], key[23:16]};
    rx_valid = 1'b1;
    while (!rx_ready)
      @(posedge sys_clk) #1;
    @(posedge sys_clk) #1;
    rx_valid = 1'b0;
    for (int k = 0; k < 600 && n_pkt == n0; k++)
      @(posedge sys_clk) #1;
    chk("replies", n0 + 1, n_pkt);
    chk("reply type", rt, host.q[0]);
    chk("reply len", rl, host.q[1]);
    chk("reply size", rl + 2, host.q.size());
    eb = (rt == 8'h43) ? 8'h30 : b;
    for (int i = 0; i < rl; i++)
      chk("reply byte", (rt == 8'h41) ? VTXT[127-8*i-:8] : eb + 8'(i), host.q[2+i]);
  endtask

  initial
  begin
    srst = 1'b1;
    rx_valid = 1'b0;
    rx_type = 8'h00;
    rx_len = 8'h00;
    rx_payload = '0;
    slow = 1'b0;
    boot_valid = 1'b0;
    boot_top = seq(8'h30);
    boot_bottom = seq(8'h50);
    nv_user_rdata = '0;
    error_cnt = 0;
    checks = 0;
    n_rst = 0;
    n_hr = 0;
    n_od = 0;
    repeat (16) @(posedge sys_clk);
    #1 srst = 1'b0;
    chk("reset top", {16{8'h20}}, top_line);
    boot_valid = 1'b1;
    @(posedge sys_clk) #1;
    boot_valid = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("boot top", boot_top, top_line);
    chk("boot bottom", boot_bottom, bottom_line);
    foreach (rows[i])
      send(rows[i].t, rows[i].l, rows[i].b, rows[i].rt, rows[i].rl);
    chk("top line", seq(8'h41), top_line);
    chk("bottom blank", {16{8'h20}}, bottom_line);
    chk("cursor", 6'h00, {cursor_row, cursor_col});
    for (int r = 0; r < 8; r++)
      chk("glyph row", 6'(3 + r), glyph_pattern_memory[(16+r)*6+:6]);
    // the flag drops again in idle, so count every cycle it was seen high
    chk("overdue", 0, n_od);
    send(8'h08, 8'h10, 8'h61, 8'h48, 8'h00);
    chk("bottom line", seq(8'h61), bottom_line);
    // stalled host, two commands back to back
    slow = 1'b1;
    send(8'h00, 8'h10, 8'hA0, 8'h40, 8'h10);
    send(8'h03, 8'h00, 8'h00, 8'h43, 8'h10);
    slow = 1'b0;
    chk("overdue slow", 1'b1, n_od > 0);
    send(8'h05, 8'h03, 8'h00, 8'h45, 8'h00, 24'h081263);
    repeat (4) @(posedge sys_clk) #1;
    chk("restart", 1, n_rst);
    send(8'h05, 8'h03, 8'h00, 8'h45, 8'h00, 24'h0C1C61);
    repeat (1100) @(posedge sys_clk) #1;
    chk("host reset", HOST_PULSE_CYC + 1, n_hr);
    send(8'h05, 8'h03, 8'h00, 8'h45, 8'h00, 24'h030B5F);
    repeat (4) @(posedge sys_clk) #1;
    chk("power off", 1'b1, host_power_off);
    srst = 1'b1;
    repeat (16) @(posedge sys_clk);
    #1 srst = 1'b0;
    chk("power off reset", 1'b0, host_power_off);
    chk("reset top", {16{8'h20}}, top_line);
    results;
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    results;
  end
endmodule

bind lcd_module_command_decoder lcd_cmd_checker checker_i (.sys_clk, .srst, .rx_valid,
  .rx_ready, .rx_type, .rx_len, .rx_payload, .tx_valid, .tx_ready, .tx_first, .tx_last,
  .tx_data, .top_line, .bottom_line, .cursor_col, .cursor_row, .nv_user_write,
  .nv_user_wdata, .nv_save_boot, .host_reset);
`default_nettype wire
